//--- include/dpt_defines.svh
// register offsets, field positions and timing constants of the dual phase pwm timer
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH
`define DPT_ADDR_CTRL 12'h000
`define DPT_ADDR_HIGH 12'h004
`define DPT_ADDR_LOW 12'h008
`define DPT_ADDR_PERIOD 12'h00C
`define DPT_ADDR_FRZ_SET 12'h010
`define DPT_ADDR_FRZ_CLR 12'h014
`define DPT_ADDR_CLKCFG 12'h018
`define DPT_ADDR_STATUS 12'h01C
`define DPT_CTRL_RUN 0
`define DPT_CTRL_FAST_SEL 1
`define DPT_CTRL_DIV10 2
`define DPT_CTRL_CLKOUT 3
`define DPT_CLKCFG_GATE 0
`define DPT_CLKCFG_DIV_LO 1
`define DPT_RELOAD_RST 16'h0000
`define DPT_CORE_HZ 40000000
`define DPT_SLOW_HZ 32768
`define DPT_FAST_HZ 16000000
`define DPT_DIV10_COUNT 4'h9
`endif

//--- include/dpt_pkg.sv
// types of the dual phase pwm timer
package dpt_pkg;
   typedef enum logic [1:0] {
      DPT_DIV_1,
      DPT_DIV_2,
      DPT_DIV_4,
      DPT_DIV_8
   } dpt_fast_div_t;
endpackage

//--- hw/dpt_timer.sv
// dual phase pwm timer with period interrupt and apb register slave
`include "dpt_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dpt_timer #(
   parameter int CW = 16
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic [11:0] I_PADDR,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_PWM_OUT_TRUE,
   output logic O_PWM_OUT_INVERTED,
   output logic O_PERIOD_INTERRUPT
);
   // tick rates as core-clock divisors
   localparam int SLOW_DIV = `DPT_CORE_HZ / `DPT_SLOW_HZ;
   localparam int FAST_DIV = `DPT_CORE_HZ / `DPT_FAST_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic timer_run_q, timer_run_d;
   logic fast_clock_select_q, fast_clock_select_d;
   logic period_clock_div10_q, period_clock_div10_d;
   logic clock_out_mode_q, clock_out_mode_d;
   logic fast_clock_gate_q, fast_clock_gate_d;
   dpt_pkg::dpt_fast_div_t fast_clock_divider_q, fast_clock_divider_d;
   logic freeze_bit_q, freeze_bit_d;
   logic [CW-1:0] high_phase_reload_q, high_phase_reload_d;
   logic [CW-1:0] low_phase_reload_q, low_phase_reload_d;
   logic [CW-1:0] interrupt_period_reload_q, interrupt_period_reload_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   // timer state
   logic [CW-1:0] phase_counter_q, phase_counter_d;
   logic [CW-1:0] period_counter_q, period_counter_d;
   logic [CW-1:0] high_shadow_q, high_shadow_d;
   logic [CW-1:0] low_shadow_q, low_shadow_d;
   logic phase_select_q, phase_select_d;
   logic started_q, started_d;
   logic [15:0] prescale_q, prescale_d;
   logic [3:0] div10_q, div10_d;
   logic half_clk_q, half_clk_d;
   logic pwm_q, pwm_d;
   logic irq_q, irq_d;

   logic access;
   logic wr;
   logic [15:0] tick_div;
   logic tick;
   logic period_tick;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state
   assign access = I_PSEL && I_PENABLE && !pready_q;
   assign wr = access && I_PWRITE;

   always_comb begin
      timer_run_d = timer_run_q;
      fast_clock_select_d = fast_clock_select_q;
      period_clock_div10_d = period_clock_div10_q;
      clock_out_mode_d = clock_out_mode_q;
      fast_clock_gate_d = fast_clock_gate_q;
      fast_clock_divider_d = fast_clock_divider_q;
      freeze_bit_d = freeze_bit_q;
      high_phase_reload_d = high_phase_reload_q;
      low_phase_reload_d = low_phase_reload_q;
      interrupt_period_reload_d = interrupt_period_reload_q;
      prdata_d = 32'h0000_0000;
      pready_d = access;
      pslverr_d = 1'b0;
      if (access) begin
         if (I_PADDR == `DPT_ADDR_CTRL) begin
            if (I_PWRITE) begin
               timer_run_d = I_PWDATA[`DPT_CTRL_RUN];
               fast_clock_select_d = I_PWDATA[`DPT_CTRL_FAST_SEL];
               period_clock_div10_d = I_PWDATA[`DPT_CTRL_DIV10];
               clock_out_mode_d = I_PWDATA[`DPT_CTRL_CLKOUT];
            end
            prdata_d[`DPT_CTRL_RUN] = timer_run_q;
            prdata_d[`DPT_CTRL_FAST_SEL] = fast_clock_select_q;
            prdata_d[`DPT_CTRL_DIV10] = period_clock_div10_q;
            prdata_d[`DPT_CTRL_CLKOUT] = clock_out_mode_q;
         end else if (I_PADDR == `DPT_ADDR_HIGH) begin
            if (I_PWRITE) begin
               high_phase_reload_d = I_PWDATA[CW-1:0];
            end
            prdata_d[CW-1:0] = phase_counter_q;
         end else if (I_PADDR == `DPT_ADDR_LOW) begin
            if (I_PWRITE) begin
               low_phase_reload_d = I_PWDATA[CW-1:0];
            end
            prdata_d[CW-1:0] = phase_counter_q;
         end else if (I_PADDR == `DPT_ADDR_PERIOD) begin
            if (I_PWRITE) begin
               interrupt_period_reload_d = I_PWDATA[CW-1:0];
            end
            prdata_d[CW-1:0] = period_counter_q;
         end else if (I_PADDR == `DPT_ADDR_FRZ_SET) begin
            if (I_PWRITE && I_PWDATA[0]) begin
               freeze_bit_d = 1'b1;
            end
            prdata_d[0] = freeze_bit_q;
         end else if (I_PADDR == `DPT_ADDR_FRZ_CLR) begin
            if (I_PWRITE && I_PWDATA[0]) begin
               freeze_bit_d = 1'b0;
            end
            prdata_d[0] = freeze_bit_q;
         end else if (I_PADDR == `DPT_ADDR_CLKCFG) begin
            if (I_PWRITE) begin
               fast_clock_gate_d = I_PWDATA[`DPT_CLKCFG_GATE];
               fast_clock_divider_d = dpt_pkg::dpt_fast_div_t'(
                  I_PWDATA[`DPT_CLKCFG_DIV_LO +: 2]);
            end
            prdata_d[`DPT_CLKCFG_GATE] = fast_clock_gate_q;
            prdata_d[`DPT_CLKCFG_DIV_LO +: 2] = fast_clock_divider_q;
         end else if (I_PADDR == `DPT_ADDR_STATUS) begin
            prdata_d[0] = pwm_q;
            prdata_d[1] = phase_select_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer clock selection
   always_comb begin
      tick_div = 16'(SLOW_DIV);
      if (fast_clock_select_q && fast_clock_gate_q) begin
         tick_div = 16'(FAST_DIV) << fast_clock_divider_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer core
   always_comb begin
      prescale_d = prescale_q;
      div10_d = div10_q;
      half_clk_d = half_clk_q;
      phase_counter_d = phase_counter_q;
      period_counter_d = period_counter_q;
      high_shadow_d = high_shadow_q;
      low_shadow_d = low_shadow_q;
      phase_select_d = phase_select_q;
      started_d = started_q;
      pwm_d = pwm_q;
      irq_d = 1'b0;
      tick = 1'b0;
      period_tick = 1'b0;
      if (!timer_run_q) begin
         prescale_d = 16'h0000;
         div10_d = 4'h0;
         half_clk_d = 1'b0;
         phase_counter_d = `DPT_RELOAD_RST;
         period_counter_d = `DPT_RELOAD_RST;
         high_shadow_d = `DPT_RELOAD_RST;
         low_shadow_d = `DPT_RELOAD_RST;
         phase_select_d = 1'b0;
         started_d = 1'b0;
         pwm_d = 1'b0;
      end else if (!freeze_bit_q) begin
         if (prescale_q >= tick_div - 16'h0001) begin
            prescale_d = 16'h0000;
            tick = 1'b1;
         end else begin
            prescale_d = prescale_q + 16'h0001;
         end
         if (tick) begin
            half_clk_d = !half_clk_q;
            period_tick = 1'b1;
            if (period_clock_div10_q) begin
               period_tick = (div10_q == `DPT_DIV10_COUNT);
               div10_d = period_tick ? 4'h0 : div10_q + 4'h1;
            end
         end
         if (!started_q) begin
            // counters load and pwm starts high in the first running cycle, which interrupts at once without waiting for a tick
            started_d = 1'b1;
            tick = 1'b0;
            irq_d = 1'b1;
            period_counter_d = interrupt_period_reload_q;
            phase_counter_d = high_phase_reload_q;
            high_shadow_d = high_phase_reload_q;
            low_shadow_d = low_phase_reload_q;
            phase_select_d = 1'b1;
            pwm_d = 1'b1;
         end
         if (tick && period_tick && period_counter_q != '0) begin
            period_counter_d = period_counter_q - 1'b1;
         end
         if (tick) begin
            if (phase_counter_q != '0) begin
               phase_counter_d = phase_counter_q - 1'b1;
            end else if (!phase_select_q && period_counter_q == '0) begin
               irq_d = 1'b1;
               period_counter_d = interrupt_period_reload_q;
               phase_counter_d = high_phase_reload_q;
               high_shadow_d = high_phase_reload_q;
               low_shadow_d = low_phase_reload_q;
               phase_select_d = 1'b1;
               pwm_d = 1'b1;
            end else begin
               phase_select_d = !phase_select_q;
               phase_counter_d = phase_select_q ? low_shadow_q : high_shadow_q;
               pwm_d = !phase_select_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software written registers
   // reload registers keep their values while the timer is stopped
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         timer_run_q <= 1'b0;
         fast_clock_select_q <= 1'b0;
         period_clock_div10_q <= 1'b0;
         clock_out_mode_q <= 1'b0;
         fast_clock_gate_q <= 1'b0;
         fast_clock_divider_q <= dpt_pkg::DPT_DIV_1;
         freeze_bit_q <= 1'b0;
         high_phase_reload_q <= `DPT_RELOAD_RST;
         low_phase_reload_q <= `DPT_RELOAD_RST;
         interrupt_period_reload_q <= `DPT_RELOAD_RST;
      end else begin
         timer_run_q <= timer_run_d;
         fast_clock_select_q <= fast_clock_select_d;
         period_clock_div10_q <= period_clock_div10_d;
         clock_out_mode_q <= clock_out_mode_d;
         fast_clock_gate_q <= fast_clock_gate_d;
         fast_clock_divider_q <= fast_clock_divider_d;
         freeze_bit_q <= freeze_bit_d;
         high_phase_reload_q <= high_phase_reload_d;
         low_phase_reload_q <= low_phase_reload_d;
         interrupt_period_reload_q <= interrupt_period_reload_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus answer, held for exactly one cycle
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer state
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         phase_counter_q <= `DPT_RELOAD_RST;
         period_counter_q <= `DPT_RELOAD_RST;
         high_shadow_q <= `DPT_RELOAD_RST;
         low_shadow_q <= `DPT_RELOAD_RST;
         phase_select_q <= 1'b0;
         started_q <= 1'b0;
         prescale_q <= 16'h0000;
         div10_q <= 4'h0;
         half_clk_q <= 1'b0;
         pwm_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         phase_counter_q <= phase_counter_d;
         period_counter_q <= period_counter_d;
         high_shadow_q <= high_shadow_d;
         low_shadow_q <= low_shadow_d;
         phase_select_q <= phase_select_d;
         started_q <= started_d;
         prescale_q <= prescale_d;
         div10_q <= div10_d;
         half_clk_q <= half_clk_d;
         pwm_q <= pwm_d;
         irq_q <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin outputs
   // level of the true output: the pwm state, gated by the halved tick clock in clock-output mode
   function automatic logic pwm_level(input logic pwm, input logic clk_out, input logic half);
      pwm_level = pwm && (!clk_out || half);
   endfunction

   // both pins come from flip-flops fed by one expression, so they never overlap
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_PWM_OUT_TRUE <= 1'b0;
         O_PWM_OUT_INVERTED <= 1'b1;
      end else begin
         O_PWM_OUT_TRUE <= pwm_level(pwm_d, clock_out_mode_q, half_clk_d);
         O_PWM_OUT_INVERTED <= !pwm_level(pwm_d, clock_out_mode_q, half_clk_d);
      end
   end

   assign O_PRDATA = prdata_q;
   assign O_PREADY = pready_q;
   assign O_PSLVERR = pslverr_q;
   assign O_PERIOD_INTERRUPT = irq_q;
endmodule
`default_nettype wire

//--- testbench/dpt_timer_assertions.sv
// port assertions of the dual phase pwm timer
`timescale 1ns/10ps
`default_nettype none
module dpt_timer_assertions (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic [11:0] I_PADDR,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PWM_OUT_TRUE,
   input wire logic O_PWM_OUT_INVERTED,
   input wire logic O_PERIOD_INTERRUPT
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   logic run_q, run_d, frz_q, frz_d;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of run and freeze bits, taken from bus writes
   always_comb begin
      run_d = run_q;
      frz_d = frz_q;
      if (I_PSEL && I_PENABLE && I_PWRITE && !O_PREADY) begin
         if (I_PADDR == 12'h000) run_d = I_PWDATA[0];
         if (I_PADDR == 12'h010 && I_PWDATA[0]) frz_d = 1'b1;
         if (I_PADDR == 12'h014 && I_PWDATA[0]) frz_d = 1'b0;
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         run_q <= 1'b0;
         frz_q <= 1'b0;
      end else begin
         run_q <= run_d;
         frz_q <= frz_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_inv;
      O_PWM_OUT_INVERTED == !O_PWM_OUT_TRUE;
   endproperty
   a_inv: assert property (p_inv) else $error("inverted output not complement");
   property p_irq_pulse;
      O_PERIOD_INTERRUPT |=> !O_PERIOD_INTERRUPT;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
   property p_rst;
      $rose(I_RESET_N) |-> !O_PWM_OUT_TRUE && !O_PERIOD_INTERRUPT && !O_PREADY;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   property p_start;
      $rose(run_q) |-> ##[0:3] O_PERIOD_INTERRUPT;
   endproperty
   a_start: assert property (p_start) else $error("no interrupt at start");
   property p_stop;
      !run_q && !$past(run_q) && !$past(run_q, 2) |-> !O_PWM_OUT_TRUE && !O_PERIOD_INTERRUPT;
   endproperty
   a_stop: assert property (p_stop) else $error("stopped timer drives outputs");
   property p_frz;
      frz_q && $past(frz_q) && $past(frz_q, 2) && run_q && $past(run_q, 2)
         |-> $stable(O_PWM_OUT_TRUE) && !O_PERIOD_INTERRUPT;
   endproperty
   a_frz: assert property (p_frz) else $error("frozen timer changed");
   property p_ready;
      I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("bus answer late");
   property p_rdata;
      !O_PREADY |-> O_PRDATA == 32'h0000_0000;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside answer");
endmodule
bind dpt_timer dpt_timer_assertions u_chk (.I_CORE_CLK, .I_RESET_N, .I_PADDR, .I_PSEL,
   .I_PENABLE, .I_PWRITE, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PWM_OUT_TRUE,
   .O_PWM_OUT_INVERTED, .O_PERIOD_INTERRUPT);
`default_nettype wire

//--- testbench/dual_phase_pwm_timer_test.sv
// self-checking bench of the dual phase pwm timer
`timescale 1ns/10ps
`default_nettype none
module dual_phase_pwm_timer_test;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rd, prdata;
   logic pready, pslverr, pwm, pwm_n, irq, err;
   int fails = 0, checks = 0, cyc = 0, h;
   dpt_timer u_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PADDR(addr), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PWDATA(wdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_PWM_OUT_TRUE(pwm), .O_PWM_OUT_INVERTED(pwm_n),
      .O_PERIOD_INTERRUPT(irq));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         results();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one transfer; pready and read data are taken at the rising edge that samples them
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic hi_len(output int n);
      n = 0;
      repeat (13000) begin @(negedge clk); if (!pwm) break; end
      repeat (13000) begin @(negedge clk); if (pwm) break; end
      while (pwm === 1'b1 && n < 13000) begin @(negedge clk); n++; end
      @(posedge clk);
   endtask
   task automatic irq_gap(output int n);
      n = 0;
      repeat (3000) begin @(negedge clk); if (irq) break; end
      do begin @(negedge clk); n++; end while (irq !== 1'b1 && n < 3000);
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      check({30'h0000_0000, pwm, pwm_n}, 32'h0000_0001);
      for (int a = 4; a < 16; a += 4) begin
         apb(1'b0, a[11:0], 32'h0000_0000);
         check(rd, 32'h0000_0000);
      end
      apb(1'b1, 12'h004, 32'h0000_0005);
      apb(1'b1, 12'h008, 32'h0000_0003);
      apb(1'b1, 12'h00C, 32'h0000_0007);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0000_0000);
      check({err, rd[30:0]}, 32'h8000_0000);
      $display("test regs done");
   endtask
   task automatic t_rates();
      apb(1'b1, 12'h018, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0001);
      hi_len(h);
      check(h, 6 * 1220);
      for (int d = 3; d >= 0; d--) begin
         apb(1'b1, 12'h000, 32'h0000_0000);
         apb(1'b1, 12'h018, (d << 1) | 1);
         apb(1'b1, 12'h000, 32'h0000_0003);
         hi_len(h);
         check(h, 6 * (2 << d));
      end
      irq_gap(h);
      check(h, 20);
      $display("test rates done");
   endtask
   task automatic t_shadow();
      apb(1'b1, 12'h00C, 32'h0000_0019);
      irq_gap(h);
      check(h, 60);
      apb(1'b1, 12'h00C, 32'h0000_0007);
      $display("test shadow done");
   endtask
   task automatic t_clkout();
      apb(1'b1, 12'h000, 32'h0000_000B);
      irq_gap(h);
      h = 0;
      repeat (20) begin @(negedge clk); h += pwm; end
      @(posedge clk);
      check(h, 6);
      apb(1'b1, 12'h000, 32'h0000_0003);
      $display("test clock output done");
   endtask
   task automatic t_freeze();
      logic [31:0] v;
      apb(1'b1, 12'h010, 32'h0000_0001);
      apb(1'b0, 12'h004, 32'h0000_0000);
      v = rd;
      repeat (10) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check(rd, v);
      apb(1'b0, 12'h014, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      apb(1'b1, 12'h014, 32'h0000_0001);
      irq_gap(h);
      check(h, 20);
      $display("test freeze done");
   endtask
   task automatic t_stop();
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check({rd[30:0], pwm}, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0003);
      hi_len(h);
      check(h, 12);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0007);
      irq_gap(h);
      irq_gap(h);
      check(h, 160);
      $display("test stop done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_rates();
      t_shadow();
      t_clkout();
      t_freeze();
      t_stop();
      results();
   end
endmodule
`default_nettype wire
